// [verilog/sfm_status_map.sv]
/*
 * Status register, program counter and banked data-memory map.
 * Assumes a core that issues at most one data access and one ALU
 * operation per mclk cycle, and fetches on a separate program bus.
 */
`timescale 1ns/100ps
module sfm_status_map #(
	parameter int PROG_WORDS = sfm_pkg::PROG_WORDS_DEF,
	parameter int GPR_BYTES = 96
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic pc_load,
	input wire logic [12:0] pc_load_val,
	input wire logic pc_step,
	input wire logic irq_take,
	output logic [12:0] pc,
	output logic [12:0] prog_addr,
	input wire sfm_pkg::sfm_dreq_t dreq,
	output logic [7:0] rdata,
	output logic [8:0] data_addr,
	input wire sfm_pkg::sfm_alu_t alu,
	output logic [7:0] alu_result,
	input wire logic wdt_clear,
	input wire logic sleep_enter,
	input wire logic wdt_timeout,
	output logic [7:0] status
);
	localparam int GPR_AW = $clog2(GPR_BYTES * 4);

	logic [12:0] pc_q, pc_d;
	logic [7:0] status_q, status_d;
	logic [7:0] pointer_q, pointer_d;
	logic [7:0] gpr_q [GPR_BYTES*4];
	logic [8:0] ea;
	logic is_indirect, hit_status, hit_pointer, hit_gpr;
	logic [GPR_AW-1:0] gpr_idx;
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] b_eff;
	logic cin;
	logic flag_upd, c_upd;
	logic new_c, new_dc, new_z;

	////////////////////////////////////////////////////////////////////
	// Program counter
	// Thirteen-bit counter
	always_comb begin
		pc_d = pc_q;
		if (irq_take) begin
			pc_d = sfm_pkg::IRQ_VEC;
		end else if (pc_load) begin
			pc_d = pc_load_val;
		end else if (pc_step) begin
			pc_d = pc_q + 13'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pc_q <= sfm_pkg::RESET_VEC;
		end else begin
			pc_q <= pc_d;
		end
	end

	assign pc = pc_q;
	// Fetch bus independent of data bus
	assign prog_addr = pc_q & 13'(PROG_WORDS - 1);

	////////////////////////////////////////////////////////////////////
	// Address decode
	// Indirect through the pointer
	assign is_indirect = (dreq.ofs == sfm_pkg::INDIRECT_OFS);
	always_comb begin
		if (is_indirect) begin
			ea = {status_q[sfm_pkg::IBS_BIT], pointer_q};
		end else begin
			ea = {status_q[sfm_pkg::BSH_BIT], status_q[sfm_pkg::BSL_BIT], dreq.ofs};
		end
	end
	assign data_addr = ea;
	// Pointer mirrored in every bank too
	assign hit_status = (ea[6:0] == sfm_pkg::STATUS_OFS);
	assign hit_pointer = (ea[6:0] == sfm_pkg::POINTER_OFS);
	assign hit_gpr = (ea[6:0] >= sfm_pkg::GPR_BASE)
		&& (32'(ea[6:0] - sfm_pkg::GPR_BASE) < GPR_BYTES);
	// Each bank owns its own slice of GPR_BYTES, so no bank aliases another
	assign gpr_idx = GPR_AW'(32'(ea[8:7]) * GPR_BYTES + 32'(7'(ea[6:0] - sfm_pkg::GPR_BASE)));

	// Read data mux; unmapped reads give zero
	always_comb begin
		rdata = 8'h00;
		if (hit_status) begin
			rdata = status_q;
		end else if (hit_pointer) begin
			rdata = pointer_q;
		end else if (hit_gpr) begin
			rdata = gpr_q[gpr_idx];
		end
	end

	////////////////////////////////////////////////////////////////////
	// ALU flag computation
	// Subtract as add of complement
	always_comb begin
		b_eff = (alu.op == sfm_pkg::ALU_SUB) ? ~alu.b : alu.b;
		cin = (alu.op == sfm_pkg::ALU_SUB);
		sum9 = {1'b0, alu.a} + {1'b0, b_eff} + {8'h00, cin};
		sum5 = {1'b0, alu.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
		alu_result = 8'h00;
		new_c = status_q[sfm_pkg::C_BIT];
		new_dc = status_q[sfm_pkg::DC_BIT];
		flag_upd = 1'b0;
		c_upd = 1'b0;
		case (alu.op)
			// No-borrow polarity falls out of the complement add
			sfm_pkg::ALU_ADD, sfm_pkg::ALU_SUB: begin
				alu_result = sum9[7:0];
				new_c = sum9[8];
				new_dc = sum5[4];
				flag_upd = 1'b1;
				c_upd = 1'b1;
			end
			sfm_pkg::ALU_LOGIC: begin
				alu_result = alu.a;
				flag_upd = 1'b1;
			end
			sfm_pkg::ALU_RRF: begin
				alu_result = {status_q[sfm_pkg::C_BIT], alu.a[7:1]};
				new_c = alu.a[0];
				c_upd = 1'b1;
			end
			sfm_pkg::ALU_RLF: begin
				alu_result = {alu.a[6:0], status_q[sfm_pkg::C_BIT]};
				new_c = alu.a[7];
				c_upd = 1'b1;
			end
			sfm_pkg::ALU_CLR: begin
				alu_result = 8'h00;
				flag_upd = 1'b1;
			end
			default: begin
				alu_result = 8'h00;
			end
		endcase
		new_z = (alu_result == 8'h00);
	end

	////////////////////////////////////////////////////////////////////
	// Status and pointer registers
	always_comb begin
		status_d = status_q;
		pointer_d = pointer_q;
		if (dreq.wr && hit_status) begin
			status_d = {dreq.wdata[7:5], status_q[4:3], dreq.wdata[2:0]};
			// Clear keeps low bits for logic update
			if (dreq.flag_dest) begin
				status_d[2:0] = status_q[2:0];
			end
		end
		if (dreq.wr && hit_pointer) begin
			pointer_d = dreq.wdata;
		end
		if (flag_upd) begin
			status_d[sfm_pkg::Z_BIT] = new_z;
		end
		if (flag_upd && (alu.op == sfm_pkg::ALU_ADD || alu.op == sfm_pkg::ALU_SUB)) begin
			status_d[sfm_pkg::DC_BIT] = new_dc;
		end
		if (c_upd) begin
			status_d[sfm_pkg::C_BIT] = new_c;
		end
		if (wdt_timeout) begin
			status_d[sfm_pkg::WDT_BIT] = 1'b0;
		end else if (wdt_clear) begin
			status_d[sfm_pkg::WDT_BIT] = 1'b1;
			status_d[sfm_pkg::SLP_BIT] = 1'b1;
		end else if (sleep_enter) begin
			status_d[sfm_pkg::WDT_BIT] = 1'b1;
			status_d[sfm_pkg::SLP_BIT] = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			status_q <= sfm_pkg::STATUS_RST;
			pointer_q <= sfm_pkg::POINTER_RST;
		end else begin
			status_q <= status_d;
			pointer_q <= pointer_d;
		end
	end

	assign status = status_q;

	////////////////////////////////////////////////////////////////////
	// General-purpose RAM, written in place
	always_ff @(posedge mclk) begin
		if (dreq.wr && hit_gpr && !hit_status && !hit_pointer) begin
			gpr_q[gpr_idx] <= dreq.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	sequence clr_write_s;
		dreq.wr && hit_status && dreq.flag_dest && alu.op == sfm_pkg::ALU_CLR
			&& !wdt_timeout && !wdt_clear && !sleep_enter;
	endsequence

	pc_reset_a: assert property (@(posedge mclk) reset |=> pc == 13'h0000)
		else $error("pc not at reset vector");
	pc_irq_a: assert property (@(posedge mclk) disable iff (reset)
		irq_take |=> pc == 13'h0004)
		else $error("pc not at interrupt vector");
	pc_wrap_a: assert property (@(posedge mclk) disable iff (reset)
		prog_addr == pc % PROG_WORDS)
		else $error("program address not wrapped");
	clr_pattern_a: assert property (@(posedge mclk) disable iff (reset)
		clr_write_s |=> status[7:5] == 3'h0 && status[2] == 1'b1
		&& status[4:3] == $past(status[4:3]))
		else $error("clear of status gave wrong pattern");
	ro_flags_a: assert property (@(posedge mclk) disable iff (reset)
		!wdt_timeout && !wdt_clear && !sleep_enter |=> $stable(status[4:3]))
		else $error("read-only flags changed");
	status_mirror_a: assert property (@(posedge mclk) disable iff (reset)
		dreq.ofs == 7'h03 |-> rdata == status)
		else $error("status not seen at this bank");
	sub_borrow_a: assert property (@(posedge mclk) disable iff (reset)
		alu.op == sfm_pkg::ALU_SUB |=> status[0] == ($past(alu.a) >= $past(alu.b)))
		else $error("borrow polarity wrong");
	rotate_c_a: assert property (@(posedge mclk) disable iff (reset)
		alu.op == sfm_pkg::ALU_RRF |=> status[0] == $past(alu.a[0]))
		else $error("rotate carry wrong");
	wdt_to_a: assert property (@(posedge mclk) disable iff (reset)
		wdt_timeout |=> !status[4])
		else $error("watchdog flag not cleared");
	ind_addr_a: assert property (@(posedge mclk) disable iff (reset)
		dreq.ofs == 7'h00 |-> data_addr == {status[7], pointer_q})
		else $error("indirect address wrong");

	// Counter, bank and flag arithmetic checks
	sequence flag_wr_s;
		dreq.wr && hit_status && dreq.flag_dest
			&& !(alu.op inside {sfm_pkg::ALU_ADD, sfm_pkg::ALU_SUB});
	endsequence

	pc_step_a: assert property (@(posedge mclk) disable iff (reset)
		pc_step && !pc_load && !irq_take |=> pc == $past(pc) + 13'h0001)
		else $error("pc did not step by one");
	bank_sel_a: assert property (@(posedge mclk) disable iff (reset)
		dreq.ofs != 7'h00 |-> data_addr == {status[6:5], dreq.ofs})
		else $error("direct bank address wrong");
	ptr_mirror_a: assert property (@(posedge mclk) disable iff (reset)
		dreq.ofs == sfm_pkg::POINTER_OFS |-> rdata == pointer_q)
		else $error("pointer not seen at this bank");
	sub_twos_a: assert property (@(posedge mclk) disable iff (reset)
		alu.op == sfm_pkg::ALU_SUB |-> alu_result == 8'(alu.a - alu.b))
		else $error("subtract result wrong");
	add_carry_a: assert property (@(posedge mclk) disable iff (reset)
		alu.op == sfm_pkg::ALU_ADD |=> status[0] == ($past(alu.b) > ~$past(alu.a)))
		else $error("add carry wrong");
	nibble_add_a: assert property (@(posedge mclk) disable iff (reset)
		alu.op == sfm_pkg::ALU_ADD |=> status[1] == ($past(alu.b[3:0]) > ~$past(alu.a[3:0])))
		else $error("nibble carry wrong");
	zero_flag_a: assert property (@(posedge mclk) disable iff (reset)
		alu.op inside {sfm_pkg::ALU_ADD, sfm_pkg::ALU_SUB, sfm_pkg::ALU_LOGIC, sfm_pkg::ALU_CLR}
		|=> status[2] == ($past(alu_result) == 8'h00))
		else $error("zero flag wrong");
	flag_block_a: assert property (@(posedge mclk) disable iff (reset)
		flag_wr_s |=> status[1] == $past(status[1]))
		else $error("written nibble carry not blocked");
endmodule

// [verilog/sfm_pkg.sv]
/*
 * Package for the status-flag and memory-map block: offsets, field
 * positions, reset values, vectors and the carrier structs.
 * Assumes nothing of its surroundings.
 */
package sfm_pkg;
	// Program space
	localparam int PC_W = 13;
	localparam logic [12:0] RESET_VEC = 13'h0000;
	localparam logic [12:0] IRQ_VEC = 13'h0004;
	localparam int PROG_WORDS_DEF = 2048;
	// Data space
	localparam int DADDR_W = 9;
	localparam logic [6:0] STATUS_OFS = 7'h03;
	localparam logic [6:0] POINTER_OFS = 7'h04;
	localparam logic [6:0] INDIRECT_OFS = 7'h00;
	localparam logic [6:0] GPR_BASE = 7'h20;
	// Status field positions
	localparam int C_BIT = 0;
	localparam int DC_BIT = 1;
	localparam int Z_BIT = 2;
	localparam int SLP_BIT = 3;
	localparam int WDT_BIT = 4;
	localparam int BSL_BIT = 5;
	localparam int BSH_BIT = 6;
	localparam int IBS_BIT = 7;
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] POINTER_RST = 8'h00;

	typedef enum logic [2:0] {
		ALU_NONE, ALU_ADD, ALU_SUB, ALU_LOGIC, ALU_RRF, ALU_RLF, ALU_CLR
	} sfm_alu_op_t;

	// Data access request from the execution core
	typedef struct packed {
		logic rd;
		logic wr;
		logic [6:0] ofs;
		logic [7:0] wdata;
		logic flag_dest;
	} sfm_dreq_t;

	// Operands and operation kind of the ALU step
	typedef struct packed {
		sfm_alu_op_t op;
		logic [7:0] a;
		logic [7:0] b;
	} sfm_alu_t;
endpackage

// [dv/sfm_core_model.sv]
/* Execution-core model: drives data requests and ALU steps.
   Assumes the block samples them on the rising mclk edge. */
`timescale 1ns/100ps
module sfm_core_model (
	input wire logic mclk,
	output sfm_pkg::sfm_dreq_t dreq,
	output sfm_pkg::sfm_alu_t alu
);
	// Idle core at time zero
	initial begin
		dreq = '0;
		alu = '0;
	end
	// One access and ALU step, left standing after its edge so that a
	// following step never lowers and raises a strobe in one time step
	task automatic step(input logic wr, input logic [6:0] ofs, input logic [7:0] wd,
		input logic fd, input sfm_pkg::sfm_alu_op_t op, input logic [7:0] a,
		input logic [7:0] b);
		dreq = '{rd: !wr, wr: wr, ofs: ofs, wdata: wd, flag_dest: fd};
		alu = '{op: op, a: a, b: b};
		@(posedge mclk);
		#1;
	endtask
	// Drop the write strobe and the ALU step before idle edges
	task automatic rest();
		dreq.wr = 1'b0;
		alu.op = sfm_pkg::ALU_NONE;
	endtask
	// Read request held over one edge
	task automatic look(input logic [6:0] ofs);
		dreq = '{rd: 1'b1, wr: 1'b0, ofs: ofs, wdata: 8'h00, flag_dest: 1'b0};
		@(posedge mclk);
		#1;
	endtask
endmodule

// [dv/status_flags_memory_map_bench.sv]
/* Self-checking bench for sfm_status_map with the core model.
   Assumes the default program size of 2048 words. */
`timescale 1ns/100ps
module status_flags_memory_map_bench;
	logic mclk, reset, pc_load, pc_step, irq_take, wdt_clear, sleep_enter, wdt_timeout;
	logic [12:0] pc_load_val, pc, prog_addr;
	logic [7:0] rdata, alu_result, status;
	logic [8:0] data_addr;
	sfm_pkg::sfm_dreq_t dreq;
	sfm_pkg::sfm_alu_t alu;
	int miscompares = 0;
	int tests_run = 0;
	sfm_core_model m (.mclk(mclk), .dreq(dreq), .alu(alu));
	sfm_status_map dut (.mclk(mclk), .reset(reset), .pc_load(pc_load),
		.pc_load_val(pc_load_val), .pc_step(pc_step), .irq_take(irq_take), .pc(pc),
		.prog_addr(prog_addr), .dreq(dreq), .rdata(rdata), .data_addr(data_addr),
		.alu(alu), .alu_result(alu_result), .wdt_clear(wdt_clear),
		.sleep_enter(sleep_enter), .wdt_timeout(wdt_timeout), .status(status));
	// Clock of 10 ns
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Counts, verdict and end of run
	task automatic stop_test();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// One-cycle event pulse: 0 timeout, 1 sleep, 2 watchdog clear
	task automatic evt(input int k, input logic [7:0] exp);
		m.rest();
		{wdt_clear, sleep_enter, wdt_timeout} = 3'(1 << k);
		@(posedge mclk);
		#1;
		{wdt_clear, sleep_enter, wdt_timeout} = 3'b000;
		@(posedge mclk);
		#1;
		chk("status", {5'h00, exp}, {5'h00, status});
	endtask
	// Select bank b by a plain status write
	task automatic bank(input int b, input logic ib);
		m.step(1'b1, 7'h03, {ib, 2'(b), 5'h00}, 1'b0, sfm_pkg::ALU_NONE, 8'h00, 8'h00);
	endtask
	// Flag step from a status of 18h; the result is seen after the edge,
	// so a rotate already shifts in the carry that it has just loaded
	task automatic op(input sfm_pkg::sfm_alu_op_t o, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] r, input logic [7:0] e);
		m.step(1'b1, 7'h03, 8'h18, 1'b0, sfm_pkg::ALU_NONE, 8'h00, 8'h00);
		m.step(1'b0, 7'h20, 8'h00, 1'b0, o, a, b);
		chk("status", {5'h00, e}, {5'h00, status});
		chk("alu_result", {5'h00, r}, {5'h00, alu_result});
	endtask
	////////////////////////////////////////////////////////////////
	// Reset values, vectors, priority and wrap of the counter
	task automatic t_pc();
		chk("status", 13'h0018, {5'h00, status});
		chk("pc", 13'h0000, pc);
		pc_step = 1'b1;
		@(posedge mclk);
		#1;
		irq_take = 1'b1;
		chk("pc", 13'h0001, pc);
		@(posedge mclk);
		#1;
		irq_take = 1'b0;
		pc_load = 1'b1;
		pc_load_val = 13'h1FFF;
		chk("pc", 13'h0004, pc);
		@(posedge mclk);
		#1;
		pc_load = 1'b0;
		chk("pc", 13'h1FFF, pc);
		chk("prog_addr", 13'h07FF, prog_addr);
		@(posedge mclk);
		#1;
		pc_step = 1'b0;
		chk("pc", 13'h0000, pc);
	endtask
	// Distinct RAM per bank, status seen in every bank
	task automatic t_bank();
		for (int b = 0; b < 4; b++) begin
			bank(b, 1'b0);
			m.step(1'b1, 7'h20, 8'hA0 + 8'(b), 1'b0, sfm_pkg::ALU_NONE, 8'h00, 8'h00);
		end
		for (int b = 0; b < 4; b++) begin
			bank(b, 1'b0);
			m.look(7'h20);
			chk("ram", {5'h00, 8'hA0 + 8'(b)}, {5'h00, rdata});
			chk("data_addr", {4'h0, 2'(b), 7'h20}, {4'h0, data_addr});
			m.look(7'h03);
			chk("status", {5'h00, 1'b0, 2'(b), 5'h18}, {5'h00, rdata});
		end
	endtask
	// Indirect access through the pointer and bit 7
	task automatic t_ind();
		pc_step = 1'b1;
		m.step(1'b1, 7'h04, 8'h25, 1'b0, sfm_pkg::ALU_NONE, 8'h00, 8'h00);
		pc_step = 1'b0;
		chk("pc", 13'h0001, pc);
		m.look(7'h00);
		chk("data_addr", 13'h0025, {4'h0, data_addr});
		bank(1, 1'b1);
		m.look(7'h00);
		chk("data_addr", 13'h0125, {4'h0, data_addr});
		m.look(7'h04);
		chk("pointer", 13'h0025, {5'h00, rdata});
	endtask
	// Protected bits, clear pattern and flag results
	task automatic t_flags();
		m.step(1'b1, 7'h03, 8'hE7, 1'b0, sfm_pkg::ALU_NONE, 8'h00, 8'h00);
		chk("status", 13'h00FF, {5'h00, status});
		m.step(1'b1, 7'h03, 8'h00, 1'b1, sfm_pkg::ALU_CLR, 8'h00, 8'h00);
		chk("status", 13'h001F, {5'h00, status});
		op(sfm_pkg::ALU_SUB, 8'h05, 8'h05, 8'h00, 8'h1F);
		op(sfm_pkg::ALU_SUB, 8'h05, 8'h06, 8'hFF, 8'h18);
		op(sfm_pkg::ALU_SUB, 8'h10, 8'h01, 8'h0F, 8'h19);
		op(sfm_pkg::ALU_ADD, 8'h80, 8'h80, 8'h00, 8'h1D);
		op(sfm_pkg::ALU_ADD, 8'h08, 8'h08, 8'h10, 8'h1A);
		op(sfm_pkg::ALU_LOGIC, 8'h00, 8'h00, 8'h00, 8'h1C);
		op(sfm_pkg::ALU_RRF, 8'h01, 8'h00, 8'h80, 8'h19);
		op(sfm_pkg::ALU_RLF, 8'h80, 8'h00, 8'h01, 8'h19);
		evt(0, 8'h09);
		evt(1, 8'h11);
		evt(2, 8'h19);
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence after two cycles of reset
	initial begin
		{reset, pc_load, pc_step, irq_take} = 4'b1000;
		{wdt_clear, sleep_enter, wdt_timeout} = 3'b000;
		pc_load_val = 13'h0000;
		repeat (2) @(posedge mclk);
		#1;
		reset = 1'b0;
		t_pc();
		t_bank();
		t_ind();
		t_flags();
		stop_test();
	end
	// Cut a hang short
	initial begin
		#100000;
		miscompares++;
		stop_test();
	end
endmodule
